// file: core/cxi_core.sv
// Register file, stack pointer and interrupt entry/return control of the CPU core.
// Assumes the instruction stream marks instruction ends, the stack memory answers reads
// one cycle after the strobe, and peripherals supply enables and flag clear pulses.
// Summary of operation
// - 32 byte registers, also visible at data addresses 0x00 to 0x1F.
// - Ports: byte read/byte write, two bytes read, 16-bit write, 16-bit read.
// - Registers 26..31 form three 16-bit pointers, low byte at even address.
// - Pointers give base plus displacement, post-increment or pre-decrement.
// - Two operands read and result written back within one cycle.
// - Runs on the undivided clock; prefetch gives one instruction per clock.
// - Stack grows downward; push lowers the pointer.
// - Push lowers pointer by one; call or interrupt lowers it by two.
// - Pop raises pointer by one; return or interrupt return raises by two.
// - Stack pointer is two read/write I/O bytes at 0x3E and 0x3D, reset zero.
// - Each source has a low vector; lower vector means higher priority.
// - Interrupt taken only with its own enable and global enable set.
// - Vector select bit moves vectors to boot start; fuse moves reset vector.
// - Programmed boot lock fields suppress interrupts depending on program counter.
// - Taking an interrupt clears global enable; interrupt return sets it.
// - Hardware clears the flag on vectoring; software clears by writing one.
// - Flags stay latched while disabled; several are served by priority.
// - Level sources request only while their condition stays present.
// - After interrupt return one instruction runs before another interrupt.
// - Clear-global-enable blocks interrupts at once, even same-cycle ones.
// - Entry takes at least four cycles pushing the PC after instruction ends.
// - Entry from sleep takes four more cycles.
// - Return takes four cycles, pops PC, raises pointer by two, sets enable.
// - After set-global-enable the next instruction runs before any interrupt.
`timescale 1ns/100ps
`default_nettype none
module cxi_core
  import cxi_pkg::*;
(
  input wire logic clk_sys, // Core clock, undivided
  input wire logic rst, // Asynchronous reset, active high
  input wire logic [4:0] rd_a_addr, // Operand A register
  input wire logic [4:0] rd_b_addr, // Operand B register
  output logic [7:0] rd_a_data, // Operand A byte
  output logic [7:0] rd_b_data, // Operand B byte
  output logic [15:0] rd_word, // Pair at rd_a_addr with bit 0 cleared
  input wire logic wr_en, // Result write
  input wire logic wr_wide, // Result is 16 bits into a pair
  input wire logic [4:0] wr_addr, // Result register
  input wire logic [15:0] wr_data, // Result value
  input wire logic ptr_req, // Pointer access request
  input wire logic [1:0] ptr_sel, // 0,1,2 selects the pointer pair
  input wire cxi_pmode_t ptr_mode, // Pointer addressing mode
  input wire logic [5:0] ptr_disp, // Displacement
  output logic [15:0] ptr_addr, // Effective address, cycle after request
  input wire logic [15:0] ds_addr, // Data-space address
  input wire logic ds_wr, // Data-space write strobe
  input wire logic ds_rd, // Data-space read strobe
  input wire logic [7:0] ds_wdata, // Data-space write byte
  output logic [7:0] ds_rdata, // Read byte, cycle after strobe
  output logic ds_hit, // Read address was mapped here
  input wire logic instr_done, // Current instruction completes this cycle
  input wire logic sleeping, // Core is asleep
  input wire cxi_stk_t stack_op, // Stack adjustment by the instruction
  input wire logic sei_instr, // Set-global-enable executes
  input wire logic cli_instr, // Clear-global-enable executes
  input wire logic interrupt_exit_instr, // Interrupt return begins
  input wire logic [15:0] pc, // Program counter
  output logic [15:0] stack_pointer, // Current stack pointer
  output logic global_enable, // Global enable bit
  output logic [7:0] core_status_register, // Full status byte
  input wire logic [NIRQ-1:0] irq_flag_set, // Flag-type event pulses
  input wire logic [NIRQ-1:0] irq_flag_clr, // Write-one flag clear pulses
  input wire logic [NIRQ-1:0] irq_level, // Level-type conditions
  input wire logic [NIRQ-1:0] irq_enable, // Individual enables
  output logic [NIRQ-1:0] irq_flag, // Latched flags
  input wire logic [15:0] boot_base, // Start of boot section
  input wire logic boot_start_fuse, // Reset vector in boot section
  input wire logic app_lock_field, // Application lock programmed
  input wire logic boot_lock_field, // Boot lock programmed
  output logic [15:0] reset_vector, // Reset vector address
  output logic irq_busy, // Entry or return sequence running
  output logic irq_vec_valid, // Jump to irq_vector now
  output logic [15:0] irq_vector, // Vector of accepted interrupt
  output logic ret_valid, // Popped PC ready
  output logic [15:0] ret_pc, // Popped return address
  output logic stk_wr, // Stack memory write
  output logic stk_rd, // Stack memory read
  output logic [15:0] stk_addr, // Stack memory address
  output logic [7:0] stk_wdata, // Stack write byte
  input wire logic [7:0] stk_rdata // Stack read byte, cycle after stk_rd
);
  logic [7:0] rf [NREG];
  logic [7:0] mcu_control_register;
  cxi_state_t state;
  logic [3:0] cnt;
  logic [3:0] entry_len;
  logic hold_one;
  logic [2:0] take_idx;

  function automatic logic [15:0] pair_of(input logic [4:0] a);
    pair_of = {rf[{a[4:1], 1'b1}], rf[{a[4:1], 1'b0}]};
  endfunction

  function automatic logic [2:0] first_set(input logic [NIRQ-1:0] v);
    first_set = 3'h0;
    for (int i = NIRQ - 1; i >= 0; i--)
      if (v[i])
        first_set = i[2:0];
  endfunction

  // Register file reads, combinational for same-cycle ALU use
  assign rd_a_data = rf[rd_a_addr];
  assign rd_b_data = rf[rd_b_addr];
  assign rd_word = pair_of(rd_a_addr);

  wire [4:0] ptr_lo = PTR_BASE + {2'h0, ptr_sel, 1'b0};
  wire [15:0] ptr_val = pair_of(ptr_lo);
  wire [15:0] ptr_dec = ptr_val - 16'h0001;
  wire [15:0] ptr_inc = ptr_val + 16'h0001;
  wire ptr_upd = ptr_req && (ptr_mode == PTR_POSTINC || ptr_mode == PTR_PREDEC);
  wire [15:0] ptr_new = (ptr_mode == PTR_PREDEC) ? ptr_dec : ptr_inc;
  wire [15:0] next_ptr_addr = (ptr_mode == PTR_PREDEC) ? ptr_dec :
    (ptr_mode == PTR_DISP) ? ptr_val + {10'h000, ptr_disp} : ptr_val;

  // Data-space decode
  wire ds_rf = ds_addr <= RF_TOP;
  wire [15:0] io_off = ds_addr - IO_DS_BASE;
  wire ds_io = ds_addr >= IO_DS_BASE && io_off[15:6] == 10'h000;
  wire ds_spl = ds_io && io_off[5:0] == IO_SP_LOW;
  wire ds_sph = ds_io && io_off[5:0] == IO_SP_HIGH;
  wire ds_st = ds_io && io_off[5:0] == IO_STATUS;
  wire ds_mcu = ds_io && io_off[5:0] == IO_MCU_CTRL;
  wire ds_map = ds_rf || ds_spl || ds_sph || ds_st || ds_mcu;
  wire [7:0] ds_mux = ds_rf ? rf[ds_addr[4:0]] : ds_spl ? stack_pointer[7:0] :
    ds_sph ? stack_pointer[15:8] : ds_st ? core_status_register :
    ds_mcu ? mcu_control_register : 8'h00;

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < NREG; i++)
        rf[i] <= 8'h00;
    end
    else
    begin
      if (ptr_upd)
      begin
        rf[ptr_lo] <= ptr_new[7:0];
        rf[ptr_lo + 5'h01] <= ptr_new[15:8];
      end
      if (wr_en && wr_wide)
      begin
        rf[{wr_addr[4:1], 1'b0}] <= wr_data[7:0];
        rf[{wr_addr[4:1], 1'b1}] <= wr_data[15:8];
      end
      else if (wr_en)
        rf[wr_addr] <= wr_data[7:0];
      if (ds_wr && ds_rf)
        rf[ds_addr[4:0]] <= ds_wdata;
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      ptr_addr <= 16'h0000;
      ds_rdata <= 8'h00;
      ds_hit <= 1'b0;
    end
    else
    begin
      if (ptr_req)
        ptr_addr <= next_ptr_addr;
      if (ds_rd)
        ds_rdata <= ds_mux;
      ds_hit <= ds_rd && ds_map;
    end
  end

  // Interrupt request selection
  wire [NIRQ-1:0] req = (irq_flag & ~LEVEL_IRQ) | (irq_level & LEVEL_IRQ);
  wire [NIRQ-1:0] live = req & irq_enable;
  wire [2:0] win = first_set(live);
  wire vector_table_select = mcu_control_register[VECTOR_TABLE_SELECT_BIT];
  wire in_boot = pc >= boot_base;
  wire lock_block = (app_lock_field && !vector_table_select && in_boot) ||
    (boot_lock_field && vector_table_select && !in_boot);
  wire at_edge = instr_done || sleeping;
  wire take = state == ST_RUN && at_edge && global_enable && !cli_instr && !hold_one &&
    !lock_block && |live;
  wire [NIRQ-1:0] hw_clr = take ? (8'h01 << win) & ~LEVEL_IRQ : 8'h00;
  wire [15:0] vec_base = vector_table_select ? boot_base : 16'h0000;
  wire last = state == ST_ENTRY ? cnt == entry_len - 4'h1 : cnt == EXIT_CYC - 4'h1;
  wire exit_done = state == ST_EXIT && last;
  wire run_exit = state == ST_RUN && interrupt_exit_instr && !take;

  assign irq_busy = state != ST_RUN;
  assign irq_vec_valid = state == ST_ENTRY && last;
  assign reset_vector = boot_start_fuse ? boot_base : 16'h0000;
  assign global_enable = core_status_register[GIE_BIT];

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      irq_flag <= 8'h00;
    else
      irq_flag <= (irq_flag & ~irq_flag_clr & ~hw_clr) | (irq_flag_set & ~LEVEL_IRQ);
  end

  // Stack pointer next value
  logic [15:0] sp_adj;
  always_comb
  begin
    sp_adj = stack_pointer;
    if (state == ST_ENTRY && cnt < 4'h2)
      sp_adj = stack_pointer - 16'h0001;
    else if (state == ST_EXIT && cnt < 4'h2)
      sp_adj = stack_pointer + 16'h0001;
    else if (state == ST_RUN && !take)
    begin
      case (stack_op)
        STK_PUSH1: sp_adj = stack_pointer - 16'h0001;
        STK_PUSH2: sp_adj = stack_pointer - 16'h0002;
        STK_POP1: sp_adj = stack_pointer + 16'h0001;
        STK_POP2: sp_adj = stack_pointer + 16'h0002;
        default: sp_adj = stack_pointer;
      endcase
    end
  end
  wire [15:0] next_sp = {ds_wr && ds_sph ? ds_wdata : sp_adj[15:8],
    ds_wr && ds_spl ? ds_wdata : sp_adj[7:0]};

  // Global enable: take and clear win over set
  wire next_gie = take ? 1'b0 : cli_instr ? 1'b0 : (sei_instr || exit_done) ? 1'b1 :
    (ds_wr && ds_st) ? ds_wdata[GIE_BIT] : global_enable;
  wire [7:0] st_wr = (ds_wr && ds_st) ? ds_wdata : core_status_register;

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      stack_pointer <= {SP_RESET, SP_RESET};
      core_status_register <= STATUS_RESET;
      mcu_control_register <= MCU_CTRL_RESET;
    end
    else
    begin
      stack_pointer <= next_sp;
      core_status_register <= {next_gie, st_wr[6:0]};
      if (ds_wr && ds_mcu)
        mcu_control_register <= ds_wdata;
    end
  end

  // Entry and return sequencer
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      state <= ST_RUN;
      cnt <= 4'h0;
      entry_len <= ENTRY_CYC;
      hold_one <= 1'b0;
      take_idx <= 3'h0;
      irq_vector <= 16'h0000;
    end
    else
    begin
      hold_one <= exit_done || (hold_one && !instr_done);
      case (state)
        ST_RUN:
        begin
          cnt <= 4'h0;
          if (take)
          begin
            state <= ST_ENTRY;
            entry_len <= sleeping ? ENTRY_CYC + WAKE_CYC : ENTRY_CYC;
            take_idx <= win;
            irq_vector <= vec_base + VEC_STRIDE * {12'h000, {1'b0, win} + 4'h1};
          end
          else if (interrupt_exit_instr)
            state <= ST_EXIT;
        end
        ST_ENTRY:
        begin
          cnt <= cnt + 4'h1;
          if (last)
            state <= ST_RUN;
        end
        ST_EXIT:
        begin
          cnt <= cnt + 4'h1;
          if (last)
            state <= ST_RUN;
        end
        default: state <= ST_RUN;
      endcase
    end
  end

  // Stack memory strobes: PC low then high on entry, high then low on return
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      stk_wr <= 1'b0;
      stk_rd <= 1'b0;
      stk_addr <= 16'h0000;
      stk_wdata <= 8'h00;
      ret_pc <= 16'h0000;
      ret_valid <= 1'b0;
    end
    else
    begin
      stk_wr <= state == ST_ENTRY && cnt < 4'h2;
      stk_rd <= state == ST_EXIT && cnt < 4'h2;
      stk_addr <= state == ST_EXIT ? stack_pointer + 16'h0001 : stack_pointer;
      stk_wdata <= cnt == 4'h0 ? pc[7:0] : pc[15:8];
      if (state == ST_EXIT && cnt == 4'h2)
        ret_pc[15:8] <= stk_rdata;
      if (state == ST_EXIT && cnt == 4'h3)
        ret_pc[7:0] <= stk_rdata;
      ret_valid <= exit_done;
    end
  end

  gie_clear_a: assert property (@(posedge clk_sys) disable iff (rst) take |=> !global_enable)
    else $error("global enable not cleared on interrupt entry");
  cli_block_a: assert property (@(posedge clk_sys) disable iff (rst) cli_instr |-> !take)
    else $error("interrupt taken with clear-enable");
  flag_hwclr_a: assert property (@(posedge clk_sys) disable iff (rst)
    take && !irq_flag_set[win] && !LEVEL_IRQ[win] |=> !irq_flag[take_idx])
    else $error("flag not cleared on vectoring");
  entry_len_a: assert property (@(posedge clk_sys) disable iff (rst)
    take && !sleeping |-> ##1 !irq_vec_valid [*3] ##1 irq_vec_valid)
    else $error("entry did not take four cycles");
  wake_len_a: assert property (@(posedge clk_sys) disable iff (rst)
    take && sleeping |-> ##1 !irq_vec_valid [*7] ##1 irq_vec_valid)
    else $error("wake entry did not take eight cycles");
  entry_sp_a: assert property (@(posedge clk_sys) disable iff (rst)
    take ##1 !ds_wr [*2] |=> stack_pointer == $past(stack_pointer, 3) - 16'h0002)
    else $error("entry did not lower stack pointer by two");
  exit_seq_a: assert property (@(posedge clk_sys) disable iff (rst)
    run_exit ##1 (!ds_wr && !cli_instr) [*4] |=> global_enable &&
    stack_pointer == $past(stack_pointer, 5) + 16'h0002)
    else $error("return did not restore enable and pointer");
  pop_one_a: assert property (@(posedge clk_sys) disable iff (rst)
    state == ST_RUN && !take && stack_op == STK_POP1 && !ds_wr
    |=> stack_pointer == $past(stack_pointer) + 16'h0001)
    else $error("pop did not raise stack pointer by one");
  one_instr_a: assert property (@(posedge clk_sys) disable iff (rst)
    exit_done |=> !take until_with instr_done)
    else $error("interrupt taken before one instruction after return");
  gate_en_a: assert property (@(posedge clk_sys) disable iff (rst)
    take |-> global_enable && irq_enable[win] && req[win])
    else $error("interrupt taken while disabled");
endmodule
`default_nettype wire

// file: core/cxi_pkg.sv
// Constants and types for the core register file, stack pointer and interrupt unit.
// Assumes one clock domain and I/O addresses that sit 0x20 above in data space.
package cxi_pkg;
  localparam int NREG = 32;
  localparam int NIRQ = 8;
  localparam logic [15:0] RF_TOP = 16'h001F;
  localparam logic [15:0] IO_DS_BASE = 16'h0020;
  localparam logic [5:0] IO_MCU_CTRL = 6'h35;
  localparam logic [5:0] IO_SP_LOW = 6'h3D;
  localparam logic [5:0] IO_SP_HIGH = 6'h3E;
  localparam logic [5:0] IO_STATUS = 6'h3F;
  localparam logic [7:0] SP_RESET = 8'h00;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] MCU_CTRL_RESET = 8'h00;
  localparam int GIE_BIT = 7;
  localparam int VECTOR_TABLE_SELECT_BIT = 1;
  localparam logic [4:0] PTR_BASE = 5'h1A;
  localparam logic [15:0] VEC_STRIDE = 16'h0002;
  localparam logic [NIRQ-1:0] LEVEL_IRQ = 8'hC0;
  localparam logic [3:0] ENTRY_CYC = 4'h4;
  localparam logic [3:0] WAKE_CYC = 4'h4;
  localparam logic [3:0] EXIT_CYC = 4'h4;
  typedef enum logic [2:0] {STK_NONE, STK_PUSH1, STK_POP1, STK_PUSH2, STK_POP2} cxi_stk_t;
  typedef enum logic [1:0] {PTR_NONE, PTR_POSTINC, PTR_PREDEC, PTR_DISP} cxi_pmode_t;
  typedef enum logic [2:0] {ST_RUN = 3'b001, ST_ENTRY = 3'b010, ST_EXIT = 3'b100} cxi_state_t;
endpackage

// file: sim/cxi_stack_mem.sv
// Stack memory on the far side of the core's stack strobes.
// Assumes one clock; a read is answered one cycle after its strobe.
`timescale 1ns/100ps
`default_nettype none
module cxi_stack_mem
(
  input wire logic clk_sys, // Core clock
  input wire logic stk_wr, // Write strobe
  input wire logic stk_rd, // Read strobe
  input wire logic [15:0] stk_addr, // Byte address
  input wire logic [7:0] stk_wdata, // Write byte
  output logic [7:0] stk_rdata // Read byte
);
  logic [7:0] mem [0:1023];
  initial stk_rdata = 8'h5A;
  always @(posedge clk_sys)
  begin
    if (stk_wr)
      mem[stk_addr[9:0]] <= stk_wdata;
    // Outside a read the byte is inverted every cycle, so a stale value cannot pass
    if (stk_rd)
      stk_rdata <= mem[stk_addr[9:0]];
    else
      stk_rdata <= ~stk_rdata;
  end
endmodule
`default_nettype wire

// file: sim/cxi_core_bench.sv
// Self-checking bench for the register file, stack pointer and interrupt control.
// Assumes the stack memory model answers the core's stack reads.
`timescale 1ns/100ps
`default_nettype none
module cxi_core_bench import cxi_pkg::*;;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [4:0] rd_a_addr, rd_b_addr, wr_addr;
  logic [7:0] rd_a_data, rd_b_data, ds_wdata, ds_rdata, core_status_register, stk_wdata, stk_rdata;
  logic [15:0] rd_word, wr_data, ptr_addr, ds_addr, pc, stack_pointer, irq_vector, ret_pc, stk_addr;
  logic [15:0] boot_base, reset_vector;
  logic wr_en, wr_wide, ptr_req, ds_wr, ds_rd, ds_hit, instr_done, sleeping, sei_instr, cli_instr;
  logic interrupt_exit_instr, global_enable, boot_start_fuse, app_lock_field, boot_lock_field;
  logic irq_busy, irq_vec_valid, ret_valid, stk_wr, stk_rd;
  logic [1:0] ptr_sel;
  cxi_pmode_t ptr_mode;
  logic [5:0] ptr_disp;
  cxi_stk_t stack_op;
  logic [NIRQ-1:0] irq_flag_set, irq_flag_clr, irq_level, irq_enable, irq_flag;
  int fail_count = 0;
  int n_checks = 0;
  always #5 clk_sys = ~clk_sys;
  cxi_core cxi_core_inst (.clk_sys, .rst, .rd_a_addr, .rd_b_addr, .rd_a_data, .rd_b_data, .rd_word, .wr_en,
    .wr_wide, .wr_addr, .wr_data, .ptr_req, .ptr_sel, .ptr_mode, .ptr_disp, .ptr_addr, .ds_addr, .ds_wr, .ds_rd,
    .ds_wdata, .ds_rdata, .ds_hit, .instr_done, .sleeping, .stack_op, .sei_instr, .cli_instr, .interrupt_exit_instr,
    .pc, .stack_pointer, .global_enable, .core_status_register, .irq_flag_set, .irq_flag_clr, .irq_level,
    .irq_enable, .irq_flag, .boot_base, .boot_start_fuse, .app_lock_field, .boot_lock_field, .reset_vector,
    .irq_busy, .irq_vec_valid, .irq_vector, .ret_valid, .ret_pc, .stk_wr, .stk_rd, .stk_addr, .stk_wdata, .stk_rdata);
  cxi_stack_mem cxi_stack_mem_inst (.clk_sys, .stk_wr, .stk_rd, .stk_addr, .stk_wdata, .stk_rdata);
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  task automatic finish_test();
    if (fail_count == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic tick(input int n = 1);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic dsw(input logic [15:0] a, input logic [7:0] d);
    ds_addr = a;
    ds_wdata = d;
    ds_wr = 1'b1;
    tick();
    ds_wr = 1'b0;
    tick();
  endtask
  task automatic dsr(input logic [15:0] a, input logic [7:0] exp, input logic hit);
    ds_addr = a;
    ds_rd = 1'b1;
    tick();
    ds_rd = 1'b0;
    check("ds_rdata", {8'h00, ds_rdata}, {8'h00, exp});
    check("ds_hit", {15'h0, ds_hit}, {15'h0, hit});
    tick();
  endtask
  task automatic wide(input logic [4:0] a, input logic [15:0] d);
    wr_en = 1'b1;
    wr_wide = 1'b1;
    wr_addr = a;
    wr_data = d;
    tick();
    wr_en = 1'b0;
    wr_wide = 1'b0;
    tick();
  endtask
  task automatic ptr(input logic [1:0] s, input cxi_pmode_t m, input logic [5:0] dp, input logic [15:0] ea,
    input logic [15:0] pair);
    ptr_req = 1'b1;
    ptr_sel = s;
    ptr_mode = m;
    ptr_disp = dp;
    rd_a_addr = 5'h1A + {2'b00, s, 1'b0};
    tick();
    ptr_req = 1'b0;
    check("ptr_addr", ptr_addr, ea);
    check("pointer pair", rd_word, pair);
    tick();
  endtask
  task automatic entry(input logic [15:0] vec, input logic [15:0] pcv, input logic slp);
    logic [15:0] sp0;
    int n;
    sp0 = stack_pointer;
    pc = pcv;
    instr_done = ~slp;
    sleeping = slp;
    tick();
    instr_done = 1'b0;
    sleeping = 1'b0;
    check("irq_busy", {15'h0, irq_busy}, 16'h0001);
    check("global_enable", {15'h0, global_enable}, 16'h0000);
    n = 1;
    while (irq_vec_valid !== 1'b1 && n < 20)
    begin
      tick();
      n++;
    end
    check("entry cycles", 16'(n), 16'(ENTRY_CYC) + (slp ? 16'(WAKE_CYC) : 16'h0000));
    check("irq_vector", irq_vector, vec);
    check("sp after entry", stack_pointer, sp0 - 16'h0002);
    tick();
  endtask
  task automatic leave(input logic [15:0] pcv);
    logic [15:0] sp0;
    int n;
    sp0 = stack_pointer;
    interrupt_exit_instr = 1'b1;
    tick();
    interrupt_exit_instr = 1'b0;
    n = 0;
    while (ret_valid !== 1'b1 && n < 20)
    begin
      tick();
      n++;
    end
    check("return cycles", 16'(n), 16'(EXIT_CYC));
    check("ret_pc", ret_pc, pcv);
    check("sp after return", stack_pointer, sp0 + 16'h0002);
    check("global_enable", {15'h0, global_enable}, 16'h0001);
    tick();
  endtask
  task automatic t_regs();
    wr_en = 1'b1;
    wr_addr = 5'h05;
    wr_data = 16'h003C;
    tick();
    wr_en = 1'b0;
    rd_a_addr = 5'h05;
    rd_b_addr = 5'h06;
    dsw(16'h0006, 8'hC3);
    check("rd_a_data", {8'h00, rd_a_data}, 16'h003C);
    check("rd_b_data", {8'h00, rd_b_data}, 16'h00C3);
    dsr(16'h0005, 8'h3C, 1'b1);
    dsr(16'h0060, 8'h00, 1'b0);
    wide(5'h1A, 16'h0150);
    wide(5'h1C, 16'h0200);
    wide(5'h1E, 16'hFFFF);
    dsr(16'h001A, 8'h50, 1'b1);
    ptr(2'd0, PTR_POSTINC, 6'h00, 16'h0150, 16'h0151);
    ptr(2'd0, PTR_PREDEC, 6'h00, 16'h0150, 16'h0150);
    ptr(2'd1, PTR_DISP, 6'h3F, 16'h023F, 16'h0200);
    ptr(2'd2, PTR_POSTINC, 6'h00, 16'hFFFF, 16'h0000);
  endtask
  task automatic t_stack();
    cxi_stk_t ops [4] = '{STK_PUSH1, STK_PUSH2, STK_POP1, STK_POP2};
    logic [15:0] dlt [4] = '{16'hFFFF, 16'hFFFE, 16'h0001, 16'h0002};
    logic [15:0] sp0;
    dsw(16'h005E, 8'h02);
    dsw(16'h005D, 8'h00);
    check("stack_pointer", stack_pointer, 16'h0200);
    dsr(16'h005E, 8'h02, 1'b1);
    for (int i = 0; i < 4; i++)
    begin
      sp0 = stack_pointer;
      stack_op = ops[i];
      tick();
      check("sp after stack op", stack_pointer, sp0 + dlt[i]);
    end
    stack_op = STK_NONE;
  endtask
  task automatic t_irq();
    irq_enable = 8'h06;
    irq_flag_set = 8'h06;
    tick();
    irq_flag_set = 8'h00;
    instr_done = 1'b1;
    tick();
    check("irq_busy", {15'h0, irq_busy}, 16'h0000);
    sei_instr = 1'b1;
    tick();
    sei_instr = 1'b0;
    instr_done = 1'b0;
    check("irq_busy", {15'h0, irq_busy}, 16'h0000);
    check("irq_flag", {8'h00, irq_flag}, 16'h0006);
    entry(16'h0004, 16'h1234, 1'b0);
    check("irq_flag", {8'h00, irq_flag}, 16'h0004);
    leave(16'h1234);
    instr_done = 1'b1;
    tick();
    instr_done = 1'b0;
    check("irq_busy", {15'h0, irq_busy}, 16'h0000);
    dsw(16'h005F, 8'hA5);
    dsw(16'h0055, 8'h02);
    entry(16'h1006, 16'h0ABC, 1'b0);
    leave(16'h0ABC);
    dsr(16'h005F, 8'hA5, 1'b1);
    check("core_status_register", {8'h00, core_status_register}, 16'h00A5);
    irq_enable = 8'h07;
    irq_flag_set = 8'h01;
    instr_done = 1'b1;
    tick();
    irq_flag_set = 8'h00;
    cli_instr = 1'b1;
    tick();
    cli_instr = 1'b0;
    check("irq_busy", {15'h0, irq_busy}, 16'h0000);
    check("global_enable", {15'h0, global_enable}, 16'h0000);
    irq_flag_clr = 8'h01;
    irq_level = 8'h40;
    tick();
    irq_flag_clr = 8'h00;
    irq_level = 8'h00;
    check("irq_flag", {8'h00, irq_flag}, 16'h0000);
    irq_enable = 8'h40;
    sei_instr = 1'b1;
    tick(2);
    sei_instr = 1'b0;
    check("irq_busy", {15'h0, irq_busy}, 16'h0000);
    irq_level = 8'h40;
    boot_lock_field = 1'b1;
    pc = 16'h0100;
    tick();
    check("irq_busy", {15'h0, irq_busy}, 16'h0000);
    boot_lock_field = 1'b0;
    entry(16'h100E, 16'h0100, 1'b1);
    irq_level = 8'h00;
    leave(16'h0100);
  endtask
  initial
  begin
    {rd_a_addr, rd_b_addr, wr_addr, ds_wdata, wr_data, ds_addr, pc} = '0;
    {wr_en, wr_wide, ptr_req, ds_wr, ds_rd, instr_done, sleeping, sei_instr, cli_instr} = '0;
    {interrupt_exit_instr, boot_start_fuse, app_lock_field, boot_lock_field, ptr_sel, ptr_disp} = '0;
    {irq_flag_set, irq_flag_clr, irq_level, irq_enable} = '0;
    ptr_mode = PTR_NONE;
    stack_op = STK_NONE;
    boot_base = 16'h1000;
    tick(10);
    rst = 1'b0;
    check("stack_pointer", stack_pointer, 16'h0000);
    check("reset_vector", reset_vector, 16'h0000);
    boot_start_fuse = 1'b1;
    dsr(16'h005D, 8'h00, 1'b1);
    check("reset_vector", reset_vector, 16'h1000);
    t_regs();
    t_stack();
    t_irq();
    finish_test();
  end
  initial
  begin
    #20000;
    fail_count++;
    finish_test();
  end
endmodule
`default_nettype wire
